// [irq_controller.sv]
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
// Behaviour
// - 24 maskable sources; five choose pin or capture match, 19 internal.
// - Every maskable source owns one 8-bit control register.
// - Control bits: 7 flag, 6 mask, 5 macro, 4 context, 1:0 level.
// - Flag reads one after a request arrives, zero with none.
// - Level 0 is highest, level 3 lowest, binary 00 to 11.
// - A masked request waits pending; an unmasked one may be serviced.
// - Shared mask registers add a second mask bit; either one masks.
// - Global enable low blocks software service but not macro service.
// - Enable set by enable, cleared by disable, writable, cleared on accept.
// - External nonmaskable and watchdog beat all; their order is software set.
// - Accept only above the current level; others wait for a return.
// - With nesting control zero, level 3 nests within level 3 only.
// - In-service level is hardware kept; software reads it, writes ignored.
// - Macro service requests win over all software service, any level.
// - Fixed order 0 to 23 breaks ties of equal level; among macro requests it alone decides.
// - Break instructions and opcode trap ignore level and leave it alone.
// - Vector entry saves, raises level, clears enable, jumps to vector.
// - The request flag clears before its routine's first instruction.
// - Interrupt return restores saved state and the prior level.
// - Context entry switches to the bank in the vector word low bits.
// - Context entry loads pc from pair two, saves into two and three.
// - Context returns restore pairs two and three, rewrite pair two.
// - Each source has a fixed vector, lower or upper table by page flag.
module irq_controller import irq_pkg::*; #(
  parameter int NUM_SRC = NSRC
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels.
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Request sources.
  input wire logic [NUM_SRC-1:0] int_req,
  input wire logic [NPIN-1:0] pin_req,
  input wire logic nmi_req,
  input wire logic wdt_req,
  // Processor core.
  input wire core_cmd_t cmd,
  output logic entry_valid,
  output entry_t entry,
  output logic [2:0] active_bank,
  output logic pair2_wr,
  output logic [15:0] pair2_data
);
  if (NUM_SRC > NSRC || NUM_SRC < PIN_FIRST + NPIN) begin : g_bad
    $error("NUM_SRC out of the range the map can serve");
  end

  typedef enum {ST_IDLE, ST_OFFER} offer_state_t;

  logic [7:0] ctrl_q [NUM_SRC];
  logic [NSRC-1:0] shmask_q;
  logic [1:0] mode_q;
  logic global_irq_enable_q, table_page_flag_q, nmi_pend_q, wdt_pend_q;
  logic [NPIN-1:0] pinsel_q;
  logic [4:0] insvc_q;
  logic [2:0] bank_q;
  offer_state_t state_q;
  entry_t entry_q;
  logic pair2_wr_q;
  logic [15:0] pair2_data_q;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0] waddr_q;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [NUM_SRC-1:0] ev, eff_mask;
  logic wr_fire, ack_fire, take;
  logic [2:0] cur_lvl;
  logic sw_found, ms_found;
  logic [4:0] sw_idx, ms_idx;
  logic [1:0] sw_lvl;
  logic nmi_ok, wdt_ok;
  entry_t nxt;
  logic [31:0] rd_word;
  logic rd_ok, wr_ok;

  // Vector of a maskable source; the first two share one slot.
  function automatic logic [15:0] vec_of(input logic [4:0] idx,
                                         input logic page);
    logic [15:0] v;
    v = VEC_SHARED;
    if (idx >= VEC_SHARED_SRCS) begin
      v = VEC_FIRST + {10'h000, idx - VEC_SHARED_SRCS, 1'b0};
    end
    vec_of = page ? (v | VEC_UPPER) : v;
  endfunction

  // Drops the highest level in service, nonmaskable first.
  function automatic logic [4:0] clr_top(input logic [4:0] s);
    logic [4:0] r;
    r = s;
    if (s[NMI_SVC_BIT]) begin
      r[NMI_SVC_BIT] = 1'b0;
    end else if (s[0]) begin
      r[0] = 1'b0;
    end else if (s[1]) begin
      r[1] = 1'b0;
    end else if (s[2]) begin
      r[2] = 1'b0;
    end else begin
      r[3] = 1'b0;
    end
    clr_top = r;
  endfunction

  assign awready = !aw_hold_q && !bvalid_q;
  assign wready = !w_hold_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign ack_fire = (state_q == ST_OFFER) && cmd.ack;
  assign entry_valid = (state_q == ST_OFFER);
  assign entry = entry_q;
  assign active_bank = bank_q;
  assign pair2_wr = pair2_wr_q;
  assign pair2_data = pair2_data_q;

  // Per-source request routing and control registers.
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    if (i >= PIN_FIRST && i < PIN_FIRST + NPIN) begin : g_pin
      assign ev[i] = pinsel_q[i-PIN_FIRST] ? pin_req[i-PIN_FIRST]
                                           : int_req[i];
    end else begin : g_int
      assign ev[i] = int_req[i];
    end
    assign eff_mask[i] = ctrl_q[i][MASK_BIT] | shmask_q[i];
    src_ctrl u_src (
      .aclk(aclk),
      .aresetn(aresetn),
      .req_event(ev[i]),
      .accept(ack_fire && entry_q.kind inside {ENT_VEC, ENT_CTX, ENT_MACRO}
              && entry_q.src == 5'(i)),
      .wr_en(wr_fire && wstrb_q
             && waddr_q == OFF_CTRL0 + 8'(4 * i)),
      .wr_data(wdata_q),
      .ctrl_q(ctrl_q[i])
    );
  end

  // Current level is the highest level still in service.
  always_comb begin
    cur_lvl = LVL_IDLE;
    for (int l = 3; l >= 0; l--) begin
      if (insvc_q[l]) begin
        cur_lvl = 3'(l);
      end
    end
  end

  // Software scan ascends with a strict compare, macro scan descends; both keep the lower index on ties.
  always_comb begin
    sw_found = 1'b0;
    ms_found = 1'b0;
    sw_idx = '0;
    ms_idx = '0;
    sw_lvl = LVL_LOWEST;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (ctrl_q[i][FLAG_BIT] && !eff_mask[i] && ctrl_q[i][MACRO_BIT]) begin
        ms_found = 1'b1;
        ms_idx = 5'(i);
      end
    end
    for (int i = 0; i < NUM_SRC; i++) begin
      if (ctrl_q[i][FLAG_BIT] && !eff_mask[i]
          && !ctrl_q[i][MACRO_BIT] && global_irq_enable_q
          && !insvc_q[NMI_SVC_BIT]
          && (({1'b0, ctrl_q[i][1:0]} < cur_lvl)
              || (ctrl_q[i][1:0] == LVL_LOWEST
                  && cur_lvl == {1'b0, LVL_LOWEST}
                  && !mode_q[NEST_BIT]))
          && (!sw_found || ctrl_q[i][1:0] < sw_lvl)) begin
        sw_found = 1'b1;
        sw_idx = 5'(i);
        sw_lvl = ctrl_q[i][1:0];
      end
    end
  end

  // Offer choice: nonmaskable, then macro service, then software service.
  assign nmi_ok = nmi_pend_q && !insvc_q[NMI_SVC_BIT];
  assign wdt_ok = wdt_pend_q && !insvc_q[NMI_SVC_BIT];
  always_comb begin
    nxt = '0;
    take = 1'b1;
    if (wdt_ok && (mode_q[WDT_FIRST_BIT] || !nmi_ok)) begin
      nxt.kind = ENT_WDT;
      nxt.vector = table_page_flag_q ? (VEC_WDT | VEC_UPPER) : VEC_WDT;
    end else if (nmi_ok) begin
      nxt.kind = ENT_NMI;
      nxt.vector = table_page_flag_q ? (VEC_NMI | VEC_UPPER) : VEC_NMI;
    end else if (ms_found) begin
      nxt.kind = ENT_MACRO;
      nxt.src = ms_idx;
      nxt.level = ctrl_q[ms_idx][1:0];
      nxt.vector = vec_of(ms_idx, table_page_flag_q);
    end else if (sw_found) begin
      nxt.kind = ctrl_q[sw_idx][CTX_BIT] ? ENT_CTX : ENT_VEC;
      nxt.src = sw_idx;
      nxt.level = sw_lvl;
      nxt.vector = vec_of(sw_idx, table_page_flag_q);
    end else begin
      take = 1'b0;
    end
  end

  // The offer is frozen until the core takes it, so the core sees stable data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      entry_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            entry_q <= nxt;
            state_q <= ST_OFFER;
          end
        end
        ST_OFFER: begin
          if (cmd.ack) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Nonmaskable pending flags; a new request beats the acceptance clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_pend_q <= 1'b0;
      wdt_pend_q <= 1'b0;
    end else begin
      if (ack_fire && entry_q.kind == ENT_NMI) begin
        nmi_pend_q <= 1'b0;
      end
      if (ack_fire && entry_q.kind == ENT_WDT) begin
        wdt_pend_q <= 1'b0;
      end
      if (nmi_req) begin
        nmi_pend_q <= 1'b1;
      end
      if (wdt_req) begin
        wdt_pend_q <= 1'b1;
      end
    end
  end

  // In-service levels; break returns touch nothing since breaks raise none.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insvc_q <= '0;
    end else begin
      insvc_q <= ((cmd.irq_return_instr || cmd.bank_switch_return_instr)
                  && insvc_q != '0) ? clr_top(insvc_q) : insvc_q;
      if (ack_fire && entry_q.kind inside {ENT_VEC, ENT_CTX}) begin
        insvc_q[entry_q.level] <= 1'b1;
      end else if (ack_fire && entry_q.kind inside {ENT_NMI, ENT_WDT}) begin
        insvc_q[NMI_SVC_BIT] <= 1'b1;
      end
    end
  end

  // Global enable; acceptance outranks the instructions and the bus.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_enable_q <= 1'b0;
    end else if (ack_fire && entry_q.kind != ENT_MACRO) begin
      global_irq_enable_q <= 1'b0;
    end else if (cmd.disable_irq_instr) begin
      global_irq_enable_q <= 1'b0;
    end else if (cmd.enable_irq_instr) begin
      global_irq_enable_q <= 1'b1;
    end else if (wr_fire && wstrb_q && waddr_q == OFF_STATUS) begin
      global_irq_enable_q <= wdata_q[GLOBAL_IRQ_ENABLE_BIT];
    end
  end

  // Bank switch on context entry and pair two rewrite on context return.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_q <= '0;
      pair2_wr_q <= 1'b0;
      pair2_data_q <= '0;
    end else begin
      if (ack_fire && entry_q.kind == ENT_CTX) begin
        bank_q <= cmd.table_bank;
      end
      pair2_wr_q <= cmd.bank_switch_return_instr
                    || cmd.bank_switch_break_return_instr;
      if (cmd.bank_switch_return_instr
          || cmd.bank_switch_break_return_instr) begin
        pair2_data_q <= cmd.ret_imm;
      end
    end
  end

  // Shared masks, mode, page flag and pin selection written over the bus.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shmask_q <= {3{SHMASK_RESET}};
      mode_q <= '0;
      table_page_flag_q <= 1'b0;
      pinsel_q <= '0;
    end else if (wr_fire && wstrb_q) begin
      case (waddr_q)
        OFF_MASK0: shmask_q[7:0] <= wdata_q;
        OFF_MASK1: shmask_q[15:8] <= wdata_q;
        OFF_MASK2: shmask_q[23:16] <= wdata_q;
        OFF_MODE: mode_q <= wdata_q[1:0];
        OFF_STATUS: table_page_flag_q <= wdata_q[TABLE_PAGE_FLAG_BIT];
        OFF_SRCSEL: pinsel_q <= wdata_q[NPIN-1:0];
        default: ;
      endcase
    end
  end

  // Read map; read-only words accept writes without effect.
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    wr_ok = 1'b1;
    case (araddr)
      OFF_MASK0: rd_word[7:0] = shmask_q[7:0];
      OFF_MASK1: rd_word[7:0] = shmask_q[15:8];
      OFF_MASK2: rd_word[7:0] = shmask_q[23:16];
      OFF_MODE: rd_word[1:0] = mode_q;
      OFF_INSVC: rd_word[4:0] = insvc_q;
      OFF_STATUS: rd_word[1:0] = {table_page_flag_q, global_irq_enable_q};
      OFF_SRCSEL: rd_word[NPIN-1:0] = pinsel_q;
      OFF_BANK: rd_word[2:0] = bank_q;
      default: rd_ok = 1'b0;
    endcase
    for (int i = 0; i < NUM_SRC; i++) begin
      if (araddr == OFF_CTRL0 + 8'(4 * i)) begin
        rd_word[7:0] = ctrl_q[i];
        rd_ok = 1'b1;
      end
    end
    if (waddr_q[1:0] != 2'h0 || (waddr_q > OFF_BANK)
        || (waddr_q < OFF_MASK0 && waddr_q >= OFF_CTRL0 + 8'(4 * NUM_SRC))) begin
      wr_ok = 1'b0;
    end
  end

  // Write address and data may arrive in either order; one write at a time.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      waddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        waddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= wdata[7:0];
        wstrb_q <= wstrb[0];
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read answer comes one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_ok && araddr[1:0] == 2'h0 ? rd_word : '0;
      rresp_q <= rd_ok && araddr[1:0] == 2'h0 ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ctrl_zero_a: assert property (ctrl_q[7][3:2] == 2'h0)
    else $error("reserved control bits not zero");
  flag_set_a: assert property (ev[9] |=> ctrl_q[9][FLAG_BIT])
    else $error("request flag missed");
  mask_hold_a: assert property (state_q == ST_IDLE && take
    && nxt.kind inside {ENT_VEC, ENT_CTX, ENT_MACRO} |-> !eff_mask[nxt.src])
    else $error("masked source offered");
  ie_block_a: assert property (state_q == ST_IDLE && take
    && nxt.kind inside {ENT_VEC, ENT_CTX} |-> global_irq_enable_q)
    else $error("software service while disabled");
  ie_clear_a: assert property (ack_fire && entry_q.kind != ENT_MACRO
    |=> !global_irq_enable_q)
    else $error("enable not cleared on accept");
  level_ok_a: assert property (state_q == ST_IDLE && take
    && nxt.kind inside {ENT_VEC, ENT_CTX} |-> ({1'b0, nxt.level} < cur_lvl
    || (nxt.level == LVL_LOWEST && !mode_q[NEST_BIT])))
    else $error("level not above current");
  svc_raise_a: assert property (ack_fire && entry_q.kind == ENT_VEC
    |=> insvc_q[$past(entry_q.level)] && cur_lvl <= {1'b0, $past(entry_q.level)})
    else $error("level not raised");
  macro_win_a: assert property (state_q == ST_IDLE && ms_found
    && !nmi_ok && !wdt_ok |=> entry_q.kind == ENT_MACRO)
    else $error("macro service lost");
  nmi_win_a: assert property (state_q == ST_IDLE && nmi_ok && !wdt_ok
    |=> entry_valid && entry_q.kind == ENT_NMI)
    else $error("nonmaskable not first");
  bank_load_a: assert property (ack_fire && entry_q.kind == ENT_CTX
    |=> active_bank == $past(cmd.table_bank))
    else $error("bank not switched");
  pair2_a: assert property (cmd.bank_switch_return_instr |=> pair2_wr
    && pair2_data == $past(cmd.ret_imm))
    else $error("pair two not rewritten");
  ret_drop_a: assert property (cmd.irq_return_instr && !ack_fire
    && insvc_q == 5'h08 |=> insvc_q == 5'h00)
    else $error("level not restored");

  ctx_entry_c: cover property (ack_fire && entry_q.kind == ENT_CTX);
  macro_entry_c: cover property (ack_fire && entry_q.kind == ENT_MACRO);
  nest_l3_c: cover property (take && state_q == ST_IDLE
    && cur_lvl == 3'h3 && nxt.kind == ENT_VEC);
endmodule // irq_controller

// [irq_pkg.sv]
package irq_pkg;
  // Source count and the group whose request can come from a pin.
  localparam int NSRC = 24;
  localparam int NPIN = 5;
  localparam int PIN_FIRST = 2;
  // Register byte offsets; per-source control words start at zero.
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_MASK0 = 8'h60;
  localparam logic [7:0] OFF_MASK1 = 8'h64;
  localparam logic [7:0] OFF_MASK2 = 8'h68;
  localparam logic [7:0] OFF_MODE = 8'h6c;
  localparam logic [7:0] OFF_INSVC = 8'h70;
  localparam logic [7:0] OFF_STATUS = 8'h74;
  localparam logic [7:0] OFF_SRCSEL = 8'h78;
  localparam logic [7:0] OFF_BANK = 8'h7c;
  // Reset values.
  localparam logic [7:0] CTRL_RESET = 8'h43;
  localparam logic [7:0] SHMASK_RESET = 8'hff;
  // Control word fields.
  localparam int FLAG_BIT = 7;
  localparam int MASK_BIT = 6;
  localparam int MACRO_BIT = 5;
  localparam int CTX_BIT = 4;
  // Mode, status and in-service fields.
  localparam int NEST_BIT = 0;
  localparam int WDT_FIRST_BIT = 1;
  localparam int GLOBAL_IRQ_ENABLE_BIT = 0;
  localparam int TABLE_PAGE_FLAG_BIT = 1;
  localparam int NMI_SVC_BIT = 4;
  localparam logic [1:0] LVL_LOWEST = 2'h3;
  localparam logic [2:0] LVL_IDLE = 3'h4;
  // Vector table.
  localparam logic [15:0] VEC_NMI = 16'h0002;
  localparam logic [15:0] VEC_WDT = 16'h0004;
  localparam logic [15:0] VEC_SHARED = 16'h0006;
  localparam logic [15:0] VEC_FIRST = 16'h000a;
  localparam logic [15:0] VEC_UPPER = 16'h8000;
  localparam logic [4:0] VEC_SHARED_SRCS = 5'h02;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ENT_VEC, ENT_CTX, ENT_MACRO, ENT_NMI, ENT_WDT
  } entry_kind_t;

  typedef struct packed {
    entry_kind_t kind;
    logic [4:0] src;
    logic [1:0] level;
    logic [15:0] vector;
  } entry_t;

  typedef struct packed {
    logic enable_irq_instr;
    logic disable_irq_instr;
    logic irq_return_instr;
    logic break_return_instr;
    logic bank_switch_return_instr;
    logic bank_switch_break_return_instr;
    logic ack;
    logic [2:0] table_bank;
    logic [15:0] ret_imm;
  } core_cmd_t;
endpackage

// [src_ctrl.sv]
`timescale 1ns/1ps
module src_ctrl import irq_pkg::*; (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Hardware request and service acceptance.
  input wire logic req_event,
  input wire logic accept,
  // Software write.
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // Control word.
  output logic [7:0] ctrl_q
);
  // Bits 3:2 are never loaded, so they stay at their zero reset value.
  // A request in the same cycle as a clear or a write keeps the flag set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (wr_en) begin
        ctrl_q[7:4] <= wr_data[7:4];
        ctrl_q[1:0] <= wr_data[1:0];
      end
      if (accept) begin
        ctrl_q[FLAG_BIT] <= 1'b0;
      end
      if (req_event) begin
        ctrl_q[FLAG_BIT] <= 1'b1;
      end
    end
  end
endmodule // src_ctrl

// [core_model.sv]
`timescale 1ns/1ps
// Core side of the link: it takes each offer after a set number of cycles.
module core_model import irq_pkg::*; (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Offer from the controller and the wait before taking it.
  input wire logic entry_valid,
  input wire entry_t entry,
  input wire logic [3:0] delay,
  // Answer.
  output logic ack,
  output logic [2:0] table_bank
);
  logic [3:0] wait_q;
  // A slow core lets the offer stand, which shows whether it stays frozen.
  // The vector word's low bits are modelled as the source number's low bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack <= 1'b0;
      wait_q <= 4'h0;
      table_bank <= 3'h0;
    end else begin
      ack <= 1'b0;
      if (entry_valid && !ack) begin
        if (wait_q == delay) begin
          ack <= 1'b1;
          table_bank <= entry.src[2:0];
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule // core_model

// [prioritized_interrupt_controller_tb.sv]
`timescale 1ns/1ps
module prioritized_interrupt_controller_tb import irq_pkg::*; ();
  localparam logic [6:0] ENABLE_IRQ_INSTR = 7'h40;
  localparam logic [6:0] DISABLE_IRQ_INSTR = 7'h20;
  localparam logic [6:0] IRQ_RETURN_INSTR = 7'h10;
  localparam logic [6:0] BREAK_RETURN_INSTR = 7'h08;
  localparam logic [6:0] BANK_SWITCH_RETURN_INSTR = 7'h04;
  localparam logic [6:0] BANK_SWITCH_BREAK_RETURN_INSTR = 7'h02;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, nmi_req = 1'b0, wdt_req = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, entry_valid, pair2_wr, ack;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0] wstrb = 4'h0, delay = 4'h6;
  logic [1:0] bresp, rresp, rsp_v;
  logic [23:0] int_req = 24'h0;
  logic [4:0] pin_req = 5'h0;
  logic [2:0] active_bank, table_bank;
  logic [15:0] pair2_data;
  core_cmd_t tb_cmd = '0, cmd;
  entry_t entry;
  int err_total = 0, comparisons = 0;
  row_t rows [10] = '{'{OFF_CTRL0, 32'(CTRL_RESET), RESP_OKAY},
    '{8'h5c, 32'(CTRL_RESET), RESP_OKAY},
    '{OFF_MASK0, 32'(SHMASK_RESET), RESP_OKAY},
    '{OFF_MASK2, 32'(SHMASK_RESET), RESP_OKAY},
    '{OFF_MODE, 32'h0, RESP_OKAY}, '{OFF_INSVC, 32'h0, RESP_OKAY},
    '{OFF_STATUS, 32'h0, RESP_OKAY}, '{OFF_BANK, 32'h0, RESP_OKAY},
    '{8'h80, 32'h0, RESP_SLVERR}, '{8'h61, 32'h0, RESP_SLVERR}};

  // The clock toggles every 10 ns, a period of 20 ns.
  always #10 aclk = ~aclk;

  // The core model owns the acknowledge and the bank number.
  always_comb begin
    cmd = tb_cmd;
    cmd.ack = ack;
    cmd.table_bank = table_bank;
  end

  irq_controller DUT (.*);
  core_model core (.*);

  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches", comparisons,
      err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Address and data go out together; each is dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("write response", 32'(RESP_OKAY), 32'(bresp));
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_v = rdata;
    rsp_v = rresp;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
    input logic [31:0] e);
    axi_rd(a);
    chk(nm, e, rd_v);
  endtask

  task automatic pulse(input logic [23:0] m);
    @(posedge aclk);
    int_req <= m;
    @(posedge aclk);
    int_req <= 24'h0;
  endtask

  task automatic instr(input logic [6:0] s, input logic [15:0] imm);
    @(posedge aclk);
    tb_cmd <= core_cmd_t'({s, 3'h0, imm});
    @(posedge aclk);
    tb_cmd <= '0;
  endtask

  task automatic no_offer(input string nm);
    logic seen;
    seen = 1'b0;
    repeat (8) begin
      @(posedge aclk);
      if (entry_valid !== 1'b0) seen = 1'b1;
    end
    chk(nm, 32'h0, 32'(seen));
  endtask

  // Waits for an offer, checks it, then waits for the core to take it.
  task automatic offer(input entry_kind_t k, input logic [4:0] s,
    input logic [15:0] v, input logic [1:0] l);
    int n;
    n = 0;
    while (entry_valid !== 1'b1 && n < 20) begin
      @(posedge aclk);
      n++;
    end
    chk("offer seen", 32'h1, 32'(entry_valid));
    chk("offer kind", 32'(k), 32'(entry.kind));
    if (k != ENT_NMI && k != ENT_WDT) chk("offer source", 32'(s), 32'(entry.src));
    if (k != ENT_MACRO) chk("offer vector", 32'(v), 32'(entry.vector));
    if (k == ENT_VEC) chk("offer level", 32'(l), 32'(entry.level));
    n = 0;
    while (entry_valid !== 1'b0 && n < 20) begin
      @(posedge aclk);
      n++;
    end
  endtask

  // A hang ends the run as a mismatch.
  initial begin
    repeat (6000) @(posedge aclk);
    err_total++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axi_rd(rows[i].a);
      chk("reset read", rows[i].d, rd_v);
      chk("read response", 32'(rows[i].r), 32'(rsp_v));
    end
    $display("test reset done");
    // Shared mask still set: the request waits, then is served once clear.
    axi_wr(8'h5c, 32'h0);
    axi_wr(OFF_STATUS, 32'h1);
    pulse(24'h800000);
    no_offer("shared mask");
    for (int k = 0; k < 3; k++) axi_wr(OFF_MASK0 + 8'(4 * k), 32'h0);
    offer(ENT_VEC, 5'd23, 16'h0034, 2'h0);
    rd_chk("flag cleared", 8'h5c, 32'h0);
    rd_chk("enable cleared", OFF_STATUS, 32'h0);
    rd_chk("in service", OFF_INSVC, 32'h1);
    pulse(24'h000020);
    rd_chk("masked flag", 8'h14, 32'hc3);
    $display("test vectored done");
    axi_wr(8'h58, 32'h01);
    axi_wr(OFF_STATUS, 32'h3);
    pulse(24'h400000);
    no_offer("lower level");
    axi_wr(OFF_INSVC, 32'h0);
    rd_chk("in service kept", OFF_INSVC, 32'h1);
    instr(IRQ_RETURN_INSTR, 16'h0);
    offer(ENT_VEC, 5'd22, 16'h8032, 2'h1);
    rd_chk("in service", OFF_INSVC, 32'h2);
    instr(IRQ_RETURN_INSTR, 16'h0);
    $display("test levels done");
    axi_wr(OFF_STATUS, 32'h0);
    axi_wr(8'h20, 32'h02);
    axi_wr(8'h24, 32'h02);
    pulse(24'h000300);
    no_offer("enable off");
    instr(ENABLE_IRQ_INSTR, 16'h0);
    offer(ENT_VEC, 5'd8, 16'h0016, 2'h2);
    instr(IRQ_RETURN_INSTR, 16'h0);
    instr(ENABLE_IRQ_INSTR, 16'h0);
    offer(ENT_VEC, 5'd9, 16'h0018, 2'h2);
    instr(IRQ_RETURN_INSTR, 16'h0);
    $display("test ties done");
    axi_wr(8'h28, 32'h23);
    axi_wr(8'h2c, 32'h00);
    pulse(24'h000c00);
    offer(ENT_MACRO, 5'd10, 16'h0, 2'h3);
    no_offer("software held");
    instr(ENABLE_IRQ_INSTR, 16'h0);
    offer(ENT_VEC, 5'd11, 16'h001c, 2'h0);
    instr(IRQ_RETURN_INSTR, 16'h0);
    $display("test macro done");
    // Level 3 nests in level 3 only while the nesting control is zero.
    // A break return must not drop the level, or source 14 would slip in.
    axi_wr(8'h34, 32'h03);
    axi_wr(8'h38, 32'h03);
    for (int m = 0; m < 2; m++) begin
      axi_wr(OFF_MODE, 32'(m));
      instr(ENABLE_IRQ_INSTR, 16'h0);
      pulse(24'h002000);
      offer(ENT_VEC, 5'd13, 16'h0020, 2'h3);
      instr(ENABLE_IRQ_INSTR, 16'h0);
      pulse(24'h004000);
      if (m == 1) instr(BREAK_RETURN_INSTR, 16'h0);
      if (m == 1) no_offer("no nesting");
      if (m == 1) instr(IRQ_RETURN_INSTR, 16'h0);
      offer(ENT_VEC, 5'd14, 16'h0022, 2'h3);
      instr(IRQ_RETURN_INSTR, 16'h0);
      if (m == 0) instr(IRQ_RETURN_INSTR, 16'h0);
    end
    $display("test nesting done");
    delay <= 4'h0;
    axi_wr(8'h30, 32'h10);
    instr(ENABLE_IRQ_INSTR, 16'h0);
    pulse(24'h001000);
    offer(ENT_CTX, 5'd12, 16'h001e, 2'h0);
    chk("bank", 32'h4, 32'(active_bank));
    rd_chk("bank register", OFF_BANK, 32'h4);
    instr(BANK_SWITCH_RETURN_INSTR, 16'h1234);
    @(posedge aclk);
    chk("pair two write", 32'h1, 32'(pair2_wr));
    chk("pair two data", 32'h1234, 32'(pair2_data));
    instr(BANK_SWITCH_BREAK_RETURN_INSTR, 16'h5678);
    @(posedge aclk);
    chk("pair two break data", 32'h5678, 32'(pair2_data));
    $display("test context done");
    for (int m = 0; m < 2; m++) begin
      axi_wr(OFF_MODE, m == 1 ? 32'h2 : 32'h0);
      @(posedge aclk);
      nmi_req <= 1'b1;
      wdt_req <= 1'b1;
      @(posedge aclk);
      nmi_req <= 1'b0;
      wdt_req <= 1'b0;
      offer(m == 1 ? ENT_WDT : ENT_NMI, 5'd0,
        m == 1 ? VEC_WDT : VEC_NMI, 2'h0);
      instr(IRQ_RETURN_INSTR, 16'h0);
      offer(m == 1 ? ENT_NMI : ENT_WDT, 5'd0,
        m == 1 ? VEC_NMI : VEC_WDT, 2'h0);
      instr(IRQ_RETURN_INSTR, 16'h0);
    end
    $display("test nonmaskable done");
    // Source 2 listens to its pin once selected, and no longer to int_req.
    axi_wr(OFF_SRCSEL, 32'h1);
    pulse(24'h000004);
    rd_chk("pin ignores internal", 8'h08, 32'h43);
    @(posedge aclk);
    pin_req <= 5'h01;
    @(posedge aclk);
    pin_req <= 5'h00;
    rd_chk("pin request", 8'h08, 32'hc3);
    instr(ENABLE_IRQ_INSTR, 16'h0);
    instr(DISABLE_IRQ_INSTR, 16'h0);
    rd_chk("enable after disable", OFF_STATUS, 32'h0);
    $display("test pins done");
    close_out();
  end
endmodule // prioritized_interrupt_controller_tb
